//--- common/ovp_map.svh
// Register codes, field positions, reset values and timing counts for the input over-voltage block
`ifndef OVP_MAP_SVH
`define OVP_MAP_SVH

// ****************************************
// Command codes
// ****************************************
`define OVP_CODE_LIMIT 8'h55
`define OVP_CODE_RESP 8'h56

// ****************************************
// Response byte fields
// ****************************************
`define OVP_MODE_HI 7
`define OVP_MODE_LO 6
`define OVP_RETRY_HI 5
`define OVP_RETRY_LO 3
`define OVP_DELAY_HI 2
`define OVP_DELAY_LO 0
`define OVP_RETRY_NONE 3'h0
`define OVP_RETRY_ENDLESS 3'h7

// ****************************************
// Reset values
// ****************************************
`define OVP_LIMIT_RESET 16'h7BFF
`define OVP_RESP_RESET 8'hC0

// ****************************************
// Timing
// ****************************************
`define OVP_CLK_PERIOD_NS 25
`define OVP_UNIT_TIME_NS 1000
`define OVP_UNIT_CYCLES ((`OVP_UNIT_TIME_NS + `OVP_CLK_PERIOD_NS - 1) / `OVP_CLK_PERIOD_NS)

`endif

//--- common/ovp_pkg.sv
// Types shared by the input over-voltage fault block
package ovp_pkg;

   typedef enum logic [2:0] {
      ST_OFF,
      ST_RUN,
      ST_DELAY,
      ST_WAIT,
      ST_LATCHED
   } ovp_state_t;

   typedef enum logic [1:0] {
      MODE_IGNORE = 2'h0,
      MODE_DELAY = 2'h1,
      MODE_RETRY = 2'h2,
      MODE_LATCH = 2'h3
   } ovp_mode_t;

   typedef struct packed {
      ovp_state_t state;
      logic [15:0] limit;
      logic [7:0] resp;
      logic [31:0] tmr;
      logic [2:0] tries;
      logic fault_flag;
      logic out_en;
      logic [15:0] rd_data;
      logic rd_valid;
      logic cmd_err;
   } ovp_regs_t;

   // Delay code to time units; code 1 is not defined and is served as one unit
   function automatic logic [7:0] delay_units(input logic [2:0] code);
      logic [7:0] u;
      u = 8'h01;
      case (code)
         3'h2: u = 8'h02;
         3'h3: u = 8'h08;
         3'h4: u = 8'h10;
         3'h5: u = 8'h20;
         3'h6: u = 8'h40;
         3'h7: u = 8'h80;
         default: u = 8'h01;
      endcase
      return u;
   endfunction

endpackage

//--- common/lin_cmp_if.sv
// Linear-format compare request and result between the fault controller and its comparator
`timescale 1ns/1ps
interface lin_cmp_if;
   logic [15:0] sample;
   logic [15:0] limit;
   logic above;
   modport cmp (input sample, input limit, output above);
   modport user (output sample, output limit, input above);
endinterface

//--- hdl/lin_compare.sv
// Comparator of two linear-format words: five-bit exponent over an eleven-bit mantissa
`timescale 1ns/1ps
module lin_compare (
   lin_cmp_if.cmp cmp
);
   import ovp_pkg::*;

   // Both words scaled by 2^16 so every exponent gives a left shift
   function automatic logic signed [43:0] scale(input logic [15:0] w);
      logic [4:0] sh;
      logic [43:0] m;
      sh = {~w[15], w[14:11]};
      m = {{33{w[10]}}, w[10:0]};
      return $signed(m << sh);
   endfunction

   assign cmp.above = scale(cmp.sample) > scale(cmp.limit);

endmodule

//--- hdl/ovp_fault_ctrl.sv
// Input over-voltage limit, response byte and fault response sequencer
`timescale 1ns/1ps
`include "ovp_map.svh"
module ovp_fault_ctrl #(
   parameter int UNIT_CYCLES = `OVP_UNIT_CYCLES
) (
   input wire logic sys_clk,
   input wire logic rst,
   input wire logic cmd_valid,
   input wire logic cmd_write,
   input wire logic [7:0] cmd_code,
   input wire logic [15:0] cmd_wdata,
   input wire logic clear_faults,
   input wire logic clear_status,
   input wire logic ctrl_pin_on,
   input wire logic op_on,
   input wire logic bias_ok,
   input wire logic other_fault,
   input wire logic [15:0] vin_meas,
   output logic [15:0] rd_data,
   output logic rd_valid,
   output logic cmd_err,
   output logic out_enable,
   output logic fault_flag,
   output ovp_pkg::ovp_state_t fault_state
);
   import ovp_pkg::*;

   // ****************************************
   // Parameter check
   // ****************************************
   // The delay timer must hold 128 units
   if (UNIT_CYCLES < 1 || UNIT_CYCLES > 16777215) begin : g_bad_unit
      $error("UNIT_CYCLES out of range");
   end

   ovp_regs_t q_reg;
   ovp_regs_t q_next;
   logic on_cmd;
   logic over;
   logic clr;
   logic [2:0] retry;
   ovp_mode_t mode;
   logic [31:0] reload;

   lin_cmp_if cmp_bus ();

   assign cmp_bus.sample = vin_meas;
   assign cmp_bus.limit = q_reg.limit;
   assign over = cmp_bus.above;

   lin_compare u_cmp (
      .cmp(cmp_bus.cmp)
   );

   // ****************************************
   // Next state
   // ****************************************
   always_comb begin
      q_next = q_reg;
      q_next.rd_valid = 1'b0;
      q_next.cmd_err = 1'b0;
      on_cmd = ctrl_pin_on & op_on;
      clr = clear_faults | clear_status;
      retry = q_reg.resp[`OVP_RETRY_HI:`OVP_RETRY_LO];
      mode = ovp_mode_t'(q_reg.resp[`OVP_MODE_HI:`OVP_MODE_LO]);
      reload = 32'(delay_units(q_reg.resp[`OVP_DELAY_HI:`OVP_DELAY_LO]) * UNIT_CYCLES - 1);

      // Host command port
      if (cmd_valid) begin
         case (cmd_code)
            `OVP_CODE_LIMIT: begin
               if (cmd_write) begin
                  q_next.limit = cmd_wdata;
               end else begin
                  q_next.rd_data = q_reg.limit;
                  q_next.rd_valid = 1'b1;
               end
            end
            `OVP_CODE_RESP: begin
               if (cmd_write) begin
                  q_next.resp = cmd_wdata[7:0];
               end else begin
                  q_next.rd_data = {8'h00, q_reg.resp};
                  q_next.rd_valid = 1'b1;
               end
            end
            default: begin
               q_next.cmd_err = 1'b1;
            end
         endcase
      end

      // Status flag: detection wins over a clear in the same cycle
      if (clr) begin
         q_next.fault_flag = 1'b0;
      end
      if (over) begin
         q_next.fault_flag = 1'b1;
      end

      case (q_reg.state)
         ST_OFF: begin
            if (on_cmd) begin
               q_next.state = ST_RUN;
            end
         end
         ST_RUN: begin
            if (over) begin
               q_next.tries = 3'h0;
               q_next.tmr = reload;
               case (mode)
                  MODE_IGNORE: q_next.state = ST_RUN;
                  MODE_DELAY: q_next.state = ST_DELAY;
                  MODE_RETRY: begin
                     if (retry == `OVP_RETRY_NONE) begin
                        q_next.state = ST_LATCHED;
                     end else begin
                        q_next.state = ST_WAIT;
                     end
                  end
                  default: q_next.state = ST_LATCHED;
               endcase
            end
         end
         ST_DELAY: begin
            if (q_reg.tmr != 32'h0) begin
               q_next.tmr = q_reg.tmr - 32'h1;
            end else if (!over) begin
               q_next.state = ST_RUN;
            end else if (retry == `OVP_RETRY_NONE) begin
               q_next.state = ST_LATCHED;
            end else begin
               q_next.state = ST_WAIT;
               q_next.tmr = reload;
            end
         end
         ST_WAIT: begin
            // An attempt fails if the input is still over the limit when it starts
            if (q_reg.tmr != 32'h0) begin
               q_next.tmr = q_reg.tmr - 32'h1;
            end else if (!over) begin
               q_next.state = ST_RUN;
            end else if (retry != `OVP_RETRY_ENDLESS && 3'(q_reg.tries + 3'h1) == retry) begin
               q_next.state = ST_LATCHED;
            end else begin
               if (retry != `OVP_RETRY_ENDLESS) begin
                  q_next.tries = 3'(q_reg.tries + 3'h1);
               end
               q_next.tmr = reload;
            end
         end
         ST_LATCHED: begin
            if (clr) begin
               q_next.state = ST_OFF;
            end
         end
         default: begin
            q_next.state = ST_OFF;
         end
      endcase

      // Another fault ends any pending retry sequence
      if (other_fault && (q_reg.state == ST_WAIT || q_reg.state == ST_DELAY)) begin
         q_next.state = ST_LATCHED;
      end
      // Off command or bias loss always wins and forgets a latched fault
      if (!on_cmd || !bias_ok) begin
         q_next.state = ST_OFF;
      end
      q_next.out_en = (q_next.state == ST_RUN) || (q_next.state == ST_DELAY);
   end

   // ****************************************
   // State register
   // ****************************************
   always_ff @(posedge sys_clk) begin
      if (rst) begin
         q_reg <= '{state: ST_OFF, limit: `OVP_LIMIT_RESET, resp: `OVP_RESP_RESET, tmr: 32'h0,
                    tries: 3'h0, fault_flag: 1'b0, out_en: 1'b0, rd_data: 16'h0000,
                    rd_valid: 1'b0, cmd_err: 1'b0};
      end else begin
         q_reg <= q_next;
      end
   end

   assign rd_data = q_reg.rd_data;
   assign rd_valid = q_reg.rd_valid;
   assign cmd_err = q_reg.cmd_err;
   assign out_enable = q_reg.out_en;
   assign fault_flag = q_reg.fault_flag;
   assign fault_state = q_reg.state;

   // ****************************************
   // Checks
   // ****************************************
   logic run_ok;
   assign run_ok = ctrl_pin_on && op_on && bias_ok && !other_fault && !clear_faults && !clear_status;

   property p_limit_write;
      @(posedge sys_clk) disable iff (rst)
      (cmd_valid && cmd_write && cmd_code == `OVP_CODE_LIMIT) |=> (q_reg.limit == $past(cmd_wdata));
   endproperty
   a_limit_write: assert property (p_limit_write) else $error("limit word not stored");

   property p_resp_read;
      @(posedge sys_clk) disable iff (rst)
      (cmd_valid && !cmd_write && cmd_code == `OVP_CODE_RESP)
      |=> rd_valid && rd_data == {8'h00, $past(q_reg.resp)};
   endproperty
   a_resp_read: assert property (p_resp_read) else $error("response byte read wrong");

   property p_ignore;
      @(posedge sys_clk) disable iff (rst)
      (q_reg.state == ST_RUN && q_reg.resp[7:6] == 2'h0 && over && run_ok) |=> out_enable ##1 out_enable || !run_ok;
   endproperty
   a_ignore: assert property (p_ignore) else $error("output dropped while ignoring fault");

   property p_delay_runs;
      @(posedge sys_clk) disable iff (rst)
      (q_reg.state == ST_DELAY && q_reg.tmr != 32'h0 && run_ok) |=> out_enable && q_reg.state == ST_DELAY;
   endproperty
   a_delay_runs: assert property (p_delay_runs) else $error("output off during delay");

   property p_disable_now;
      @(posedge sys_clk) disable iff (rst)
      (q_reg.state == ST_RUN && q_reg.resp[7:6] == 2'h2 && q_reg.resp[5:3] != 3'h0 && over && run_ok)
      |=> !out_enable && q_reg.state == ST_WAIT;
   endproperty
   a_disable_now: assert property (p_disable_now) else $error("output not disabled on fault");

   property p_latched_off;
      @(posedge sys_clk) disable iff (rst)
      (q_reg.state == ST_LATCHED && !clear_faults && !clear_status && ctrl_pin_on && op_on)
      |=> !out_enable [*2];
   endproperty
   a_latched_off: assert property (p_latched_off) else $error("latched fault let output run");

   property p_clear;
      @(posedge sys_clk) disable iff (rst)
      (q_reg.state == ST_LATCHED && (clear_faults || clear_status)) |=> q_reg.state == ST_OFF;
   endproperty
   a_clear: assert property (p_clear) else $error("clear did not release latch");

   property p_off_on;
      @(posedge sys_clk) disable iff (rst)
      (!ctrl_pin_on || !op_on) ##1 (ctrl_pin_on && op_on && bias_ok) |=> q_reg.state == ST_RUN;
   endproperty
   a_off_on: assert property (p_off_on) else $error("off then on did not restart");

   property p_no_retry;
      @(posedge sys_clk) disable iff (rst)
      (q_reg.state == ST_RUN && q_reg.resp[7:6] == 2'h2 && q_reg.resp[5:3] == 3'h0 && over && run_ok)
      |=> q_reg.state == ST_LATCHED;
   endproperty
   a_no_retry: assert property (p_no_retry) else $error("restart tried with retry zero");

   property p_retry_limit;
      @(posedge sys_clk) disable iff (rst)
      (q_reg.state == ST_WAIT && q_reg.tmr == 32'h0 && over && run_ok && retry != 3'h7
       && 3'(q_reg.tries + 3'h1) == retry) |=> q_reg.state == ST_LATCHED;
   endproperty
   a_retry_limit: assert property (p_retry_limit) else $error("retry count not honoured");

   property p_interval;
      @(posedge sys_clk) disable iff (rst)
      (q_reg.state != ST_WAIT ##1 q_reg.state == ST_WAIT)
      |-> q_reg.tmr == 32'(delay_units($past(q_reg.resp[2:0])) * UNIT_CYCLES - 1);
   endproperty
   a_interval: assert property (p_interval) else $error("retry interval wrong");

   property p_endless;
      @(posedge sys_clk) disable iff (rst)
      (q_reg.state == ST_WAIT && q_reg.tmr == 32'h0 && over && run_ok && retry == 3'h7) |=> q_reg.state == ST_WAIT;
   endproperty
   a_endless: assert property (p_endless) else $error("endless retry stopped");

   property p_detect;
      @(posedge sys_clk) disable iff (rst)
      over |=> fault_flag;
   endproperty
   a_detect: assert property (p_detect) else $error("over-voltage not flagged");

endmodule

//--- verification/ovp_host_model.sv
// Host side model: command port, fault clears and on/off controls
`timescale 1ns/1ps
module ovp_host_model (
   input wire logic sys_clk,
   output logic cmd_valid,
   output logic cmd_write,
   output logic [7:0] cmd_code,
   output logic [15:0] cmd_wdata,
   output logic clear_faults,
   output logic clear_status,
   output logic ctrl_pin_on,
   output logic op_on,
   output logic bias_ok
);
   initial begin
      cmd_valid = 1'b0;
      cmd_write = 1'b0;
      cmd_code = 8'h00;
      cmd_wdata = 16'h0000;
      clear_faults = 1'b0;
      clear_status = 1'b0;
      ctrl_pin_on = 1'b1;
      op_on = 1'b1;
      bias_ok = 1'b1;
   end
   // Released fields are inverted so stale values never look valid
   task automatic xfer(input logic wr, input logic [7:0] code, input logic [15:0] data);
      @(posedge sys_clk);
      cmd_valid <= 1'b1;
      cmd_write <= wr;
      cmd_code <= code;
      cmd_wdata <= data;
      @(posedge sys_clk);
      cmd_valid <= 1'b0;
      cmd_write <= ~wr;
      cmd_code <= ~code;
      cmd_wdata <= ~data;
   endtask
   task automatic pulse_clear(input logic all);
      @(posedge sys_clk);
      if (all) clear_faults <= 1'b1;
      else clear_status <= 1'b1;
      @(posedge sys_clk);
      clear_faults <= 1'b0;
      clear_status <= 1'b0;
   endtask
   // Bit 0 pin, bit 1 operation command, bit 2 bias power
   task automatic off_on(input logic [2:0] how);
      @(posedge sys_clk);
      if (how[0]) ctrl_pin_on <= 1'b0;
      if (how[1]) op_on <= 1'b0;
      if (how[2]) bias_ok <= 1'b0;
      repeat (2) @(posedge sys_clk);
      ctrl_pin_on <= 1'b1;
      op_on <= 1'b1;
      bias_ok <= 1'b1;
   endtask
endmodule

//--- verification/input_overvoltage_fault_response_tb_top.sv
// Self-checking bench for the input over-voltage fault block
`timescale 1ns/1ps
module input_overvoltage_fault_response_tb_top;
   import ovp_pkg::*;
   // ****************************************
   // Signals
   // ****************************************
   localparam int UC = 2;
   localparam logic [15:0] LIM = 16'h0064;
   localparam logic [15:0] OVER = 16'h0065;
   localparam logic [15:0] UNDER = 16'h0050;
   logic sys_clk, rst, cmd_valid, cmd_write, clear_faults, clear_status;
   logic ctrl_pin_on, op_on, bias_ok, other_fault, rd_valid, cmd_err, out_enable, fault_flag;
   logic [7:0] cmd_code;
   logic [15:0] cmd_wdata, vin_meas, rd_data;
   ovp_state_t fault_state;
   int err_total = 0;
   int total_checks = 0;
   int units [8] = '{1, 1, 2, 8, 16, 32, 64, 128};
   int s, d, cnt;
   logic on_ok;
   initial begin
      sys_clk = 1'b0;
      forever #12.5 sys_clk = ~sys_clk;
   end
   ovp_fault_ctrl #(.UNIT_CYCLES(UC)) ovp_fault_ctrl_i (.sys_clk(sys_clk), .rst(rst), .cmd_valid(cmd_valid),
      .cmd_write(cmd_write), .cmd_code(cmd_code), .cmd_wdata(cmd_wdata), .clear_faults(clear_faults),
      .clear_status(clear_status), .ctrl_pin_on(ctrl_pin_on), .op_on(op_on), .bias_ok(bias_ok),
      .other_fault(other_fault), .vin_meas(vin_meas), .rd_data(rd_data), .rd_valid(rd_valid),
      .cmd_err(cmd_err), .out_enable(out_enable), .fault_flag(fault_flag), .fault_state(fault_state));
   ovp_host_model ovp_host_model_i (.sys_clk(sys_clk), .cmd_valid(cmd_valid), .cmd_write(cmd_write),
      .cmd_code(cmd_code), .cmd_wdata(cmd_wdata), .clear_faults(clear_faults), .clear_status(clear_status),
      .ctrl_pin_on(ctrl_pin_on), .op_on(op_on), .bias_ok(bias_ok));
   // ****************************************
   // Tasks
   // ****************************************
   task automatic summarize();
      if (err_total == 0 && total_checks > 0) $display("*** PASS ***");
      else $display("*** FAIL ***");
      $finish;
   endtask
   task automatic chk(input logic [15:0] got, input logic [15:0] exp);
      total_checks++;
      if (got !== exp) begin
         err_total++;
         $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   task automatic chk_st(input ovp_state_t exp);
      chk({13'h0000, fault_state}, {13'h0000, exp});
   endtask
   task automatic step(input int n);
      repeat (n) @(negedge sys_clk);
   endtask
   task automatic set_vin(input logic [15:0] v);
      @(posedge sys_clk);
      vin_meas <= v;
   endtask
   task automatic rd(input logic [7:0] code, input logic [15:0] exp);
      ovp_host_model_i.xfer(1'b0, code, 16'h0000);
      @(negedge sys_clk);
      chk({15'h0000, rd_valid}, 16'h0001);
      chk(rd_data, exp);
   endtask
   // Write the response, raise the input and check the output one cycle later
   task automatic trip(input logic [7:0] resp, input logic off);
      ovp_host_model_i.xfer(1'b1, 8'h56, {8'h00, resp});
      set_vin(OVER);
      step(1);
      chk({15'h0000, out_enable}, 16'h0001);
      step(1);
      chk({15'h0000, out_enable}, {15'h0000, ~off});
   endtask
   task automatic release_fault(input int k);
      if (k < 2) ovp_host_model_i.pulse_clear(k == 0);
      else ovp_host_model_i.off_on((k == 5) ? 3'h4 : 3'(k - 1));
      step(5);
   endtask
   // ****************************************
   // Sequence
   // ****************************************
   initial begin
      rst = 1'b1;
      other_fault = 1'b0;
      vin_meas = 16'h0000;
      repeat (2) @(posedge sys_clk);
      rst <= 1'b0;
      rd(8'h55, 16'h7BFF);
      rd(8'h56, 16'h00C0);
      ovp_host_model_i.xfer(1'b1, 8'h55, LIM);
      rd(8'h55, LIM);
      ovp_host_model_i.xfer(1'b1, 8'h56, 16'hAB12);
      rd(8'h56, 16'h0012);
      ovp_host_model_i.xfer(1'b0, 8'h57, 16'h0000);
      @(negedge sys_clk);
      chk({15'h0000, cmd_err}, 16'h0001);
      set_vin(LIM);
      step(3);
      chk({15'h0000, fault_flag}, 16'h0000);
      trip(8'h00, 1'b0);
      step(4);
      chk({15'h0000, out_enable}, 16'h0001);
      chk({15'h0000, fault_flag}, 16'h0001);
      set_vin(UNDER);
      ovp_host_model_i.pulse_clear(1'b0);
      step(2);
      chk({15'h0000, fault_flag}, 16'h0000);
      // Every clearing path, each from a fresh latch
      for (int k = 0; k < 6; k++) begin
         trip(8'hC0, 1'b1);
         set_vin(UNDER);
         step(6);
         chk_st(ST_LATCHED);
         chk({15'h0000, out_enable}, 16'h0000);
         release_fault(k);
         chk_st(ST_RUN);
         chk({15'h0000, out_enable}, 16'h0001);
      end
      trip(8'h80, 1'b1);
      step(10);
      set_vin(UNDER);
      step(5);
      chk_st(ST_LATCHED);
      release_fault(0);
      // Retry counts 1 to 6 with growing delays; attempts one delay apart, latch on the last
      for (int n = 1; n < 7; n++) begin
         d = (n == 1) ? 0 : n;
         s = units[d] * UC;
         trip({2'b10, 3'(n), 3'(d)}, 1'b1);
         step(n * s - 1);
         chk_st(ST_WAIT);
         step(1);
         chk_st(ST_LATCHED);
         set_vin(UNDER);
         release_fault(0);
      end
      trip(8'h90, 1'b1);
      set_vin(UNDER);
      step(6);
      chk_st(ST_RUN);
      trip(8'hB8, 1'b1);
      step(40);
      chk_st(ST_WAIT);
      @(posedge sys_clk);
      other_fault <= 1'b1;
      step(2);
      chk_st(ST_LATCHED);
      @(posedge sys_clk);
      other_fault <= 1'b0;
      set_vin(UNDER);
      release_fault(0);
      // Delay code 7 keeps the output up for 128 units before deciding
      trip(8'h47, 1'b0);
      cnt = 0;
      on_ok = 1'b1;
      while (fault_state === ST_DELAY && cnt < 400) begin
         on_ok = on_ok & out_enable;
         cnt++;
         step(1);
      end
      if (cnt >= 400) begin
         err_total++;
         summarize();
      end
      chk({15'h0000, on_ok}, 16'h0001);
      chk({15'h0000, cnt inside {[255:257]}}, 16'h0001);
      chk_st(ST_LATCHED);
      summarize();
   end
endmodule
